// file: core/pcsc_ctrl.sv
// Card socket strobe controller: drives the card control strobes for one access.
// Assumes a requester on mclk_in that raises its request for one cycle and holds the access fields until done_out pulses.
`default_nettype none
// Summary of operation
// - Output enable strobes reads of common memory and attribute space.
// - Write enable strobes writes to common memory and attribute space.
// - Write enable also strobes variable-latency I/O writes.
// - A separate I/O write strobe serves every card I/O write except variable-latency I/O writes.
// - A separate I/O read strobe serves every card I/O read except variable-latency I/O reads, which use output enable.
// - Two lane enables: upper one high byte, lower one low byte.
// - Card holds wait low to stretch; the strobe stays active meanwhile.
// - Socket select low picks socket zero, high socket one, loaded with address and held after the access.
// - Register select asserted with address for attribute-space memory accesses.
////////////////////////////////////////////////////////////////////////////////
module pcsc_ctrl (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire pcsc_pkg::pcsc_space_t req_space_in,
  input wire logic req_socket_in,
  input wire logic [1:0] req_lanes_in,
  input wire logic card_wait_n_in,
  input wire logic card_io_width_ack_n_in,
  output logic busy_out,
  output logic done_out,
  output logic io_is_16_out,
  output logic card_mem_read_strobe_n_out,
  output logic card_mem_write_strobe_n_out,
  output logic card_io_read_strobe_n_out,
  output logic card_io_write_strobe_n_out,
  output logic [1:0] card_lane_enable_n_out,
  output logic socket_select_out,
  output logic attribute_space_select_n_out
);
  import pcsc_pkg::*;

  pcsc_sync_if sync_bus ();

  pcsc_sync u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .card_wait_n_in(card_wait_n_in),
    .card_io_width_ack_n_in(card_io_width_ack_n_in),
    .sync(sync_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  pcsc_state_t state_r;
  pcsc_state_t state_nxt;
  logic [PCSC_CNT_W-1:0] cnt_r;
  logic [PCSC_CNT_W-1:0] cnt_nxt;
  logic write_r;
  logic write_nxt;
  pcsc_space_t space_r;
  pcsc_space_t space_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    write_nxt = write_r;
    space_nxt = space_r;
    done_nxt = 1'b0;
    case (state_r)
      PCSC_ST_IDLE: begin
        if (req_in) begin
          write_nxt = req_write_in;
          space_nxt = req_space_in;
          cnt_nxt = PCSC_SETUP_CNT;
          state_nxt = PCSC_ST_SETUP;
        end
      end
      PCSC_ST_SETUP: begin
        if (cnt_r > PCSC_CNT_W'(1)) begin
          cnt_nxt = cnt_r - PCSC_CNT_W'(1);
        end else begin
          cnt_nxt = PCSC_STROBE_CNT;
          state_nxt = PCSC_ST_STROBE;
        end
      end
      PCSC_ST_STROBE: begin
        if (cnt_r > PCSC_CNT_W'(1)) begin
          cnt_nxt = cnt_r - PCSC_CNT_W'(1);
        end else if (sync_bus.wait_n) begin
          cnt_nxt = PCSC_HOLD_CNT;
          state_nxt = PCSC_ST_HOLD;
        end
      end
      PCSC_ST_HOLD: begin
        if (cnt_r > PCSC_CNT_W'(1)) begin
          cnt_nxt = cnt_r - PCSC_CNT_W'(1);
        end else begin
          done_nxt = 1'b1;
          state_nxt = PCSC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = PCSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= PCSC_ST_IDLE;
      cnt_r <= '0;
      write_r <= 1'b0;
      space_r <= PCSC_SP_COMMON;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      write_r <= write_nxt;
      space_r <= space_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so the card sees clean edges
  logic mem_rd_n_r;
  logic mem_rd_n_nxt;
  logic mem_wr_n_r;
  logic mem_wr_n_nxt;
  logic io_rd_n_r;
  logic io_rd_n_nxt;
  logic io_wr_n_r;
  logic io_wr_n_nxt;
  logic [1:0] lane_n_r;
  logic [1:0] lane_n_nxt;
  logic sock_r;
  logic sock_nxt;
  logic attr_n_r;
  logic attr_n_nxt;
  logic wide_r;
  logic wide_nxt;
  logic strobe_on;
  logic addr_phase;

  always_comb begin
    strobe_on = (state_nxt == PCSC_ST_STROBE);
    addr_phase = (state_nxt != PCSC_ST_IDLE);
    // Only one case item can match, so only one strobe goes low
    mem_rd_n_nxt = 1'b1;
    mem_wr_n_nxt = 1'b1;
    io_rd_n_nxt = 1'b1;
    io_wr_n_nxt = 1'b1;
    if (strobe_on) begin
      case (space_nxt)
        PCSC_SP_COMMON, PCSC_SP_ATTR: begin
          mem_rd_n_nxt = write_nxt;
          mem_wr_n_nxt = !write_nxt;
        end
        PCSC_SP_VLIO: begin
          // Variable latency I/O reads use the memory output enable too
          mem_rd_n_nxt = write_nxt;
          mem_wr_n_nxt = !write_nxt;
        end
        PCSC_SP_IO: begin
          io_rd_n_nxt = write_nxt;
          io_wr_n_nxt = !write_nxt;
        end
        default: begin
          mem_rd_n_nxt = 1'b1;
        end
      endcase
    end
    // Lanes and register select follow the address phase; socket select loads at request and holds after it
    lane_n_nxt = addr_phase ? ~req_lanes_latched(state_r, req_lanes_in, lane_n_r) : 2'h3;
    sock_nxt = (state_r == PCSC_ST_IDLE && req_in) ? req_socket_in : sock_r;
    attr_n_nxt = !(addr_phase && space_nxt == PCSC_SP_ATTR);
    // Width acknowledge sampled while an I/O strobe is active
    wide_nxt = wide_r;
    if (state_r == PCSC_ST_STROBE && space_r == PCSC_SP_IO) begin
      wide_nxt = !sync_bus.io_width_ack_n;
    end
  end

  // Lane choice is captured at request and held through the access
  function automatic logic [1:0] req_lanes_latched(
    input pcsc_state_t st,
    input logic [1:0] lanes,
    input logic [1:0] held_n
  );
    req_lanes_latched = (st == PCSC_ST_IDLE) ? lanes : ~held_n;
  endfunction

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_rd_n_r <= 1'b1;
      mem_wr_n_r <= 1'b1;
      io_rd_n_r <= 1'b1;
      io_wr_n_r <= 1'b1;
      lane_n_r <= 2'h3;
      sock_r <= 1'b0;
      attr_n_r <= 1'b1;
      wide_r <= 1'b0;
    end else begin
      mem_rd_n_r <= mem_rd_n_nxt;
      mem_wr_n_r <= mem_wr_n_nxt;
      io_rd_n_r <= io_rd_n_nxt;
      io_wr_n_r <= io_wr_n_nxt;
      lane_n_r <= lane_n_nxt;
      sock_r <= sock_nxt;
      attr_n_r <= attr_n_nxt;
      wide_r <= wide_nxt;
    end
  end

  assign busy_out = (state_r != PCSC_ST_IDLE);
  assign done_out = done_r;
  assign io_is_16_out = wide_r;
  assign card_mem_read_strobe_n_out = mem_rd_n_r;
  assign card_mem_write_strobe_n_out = mem_wr_n_r;
  assign card_io_read_strobe_n_out = io_rd_n_r;
  assign card_io_write_strobe_n_out = io_wr_n_r;
  assign card_lane_enable_n_out = lane_n_r;
  assign socket_select_out = sock_r;
  assign attribute_space_select_n_out = attr_n_r;
endmodule
`default_nettype wire

// file: core/pcsc_pkg.sv
// Package for the card socket strobe controller: modes, states, timing counts.
// Assumes a single 125 MHz controller clock and no software registers.
`default_nettype none
package pcsc_pkg;
  localparam int unsigned PCSC_CLK_MHZ = 125;
  // Minimum strobe active time in ns and its cycle count, rounded up
  localparam int unsigned PCSC_STROBE_NS = 40;
  localparam int unsigned PCSC_STROBE_CYC = (PCSC_STROBE_NS * PCSC_CLK_MHZ + 999) / 1000;
  // Setup and hold around the strobe, in cycles
  localparam int unsigned PCSC_SETUP_CYC = 1;
  localparam int unsigned PCSC_HOLD_CYC = 1;
  localparam int unsigned PCSC_CNT_W = 8;
  localparam logic [PCSC_CNT_W-1:0] PCSC_STROBE_CNT = PCSC_CNT_W'(PCSC_STROBE_CYC);
  localparam logic [PCSC_CNT_W-1:0] PCSC_SETUP_CNT = PCSC_CNT_W'(PCSC_SETUP_CYC);
  localparam logic [PCSC_CNT_W-1:0] PCSC_HOLD_CNT = PCSC_CNT_W'(PCSC_HOLD_CYC);
  // Access space codes
  typedef enum logic [1:0] {
    PCSC_SP_COMMON = 2'h0,
    PCSC_SP_ATTR = 2'h1,
    PCSC_SP_IO = 2'h2,
    PCSC_SP_VLIO = 2'h3
  } pcsc_space_t;
  typedef enum logic [3:0] {
    PCSC_ST_IDLE = 4'h1,
    PCSC_ST_SETUP = 4'h2,
    PCSC_ST_STROBE = 4'h4,
    PCSC_ST_HOLD = 4'h8
  } pcsc_state_t;
endpackage
`default_nettype wire

// file: core/pcsc_sync.sv
// Two-flop synchroniser for the card's wait and width acknowledge pins.
// Assumes the pins are asynchronous to mclk_in.
`default_nettype none
module pcsc_sync (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic card_wait_n_in,
  input wire logic card_io_width_ack_n_in,
  pcsc_sync_if.src sync
);
  logic [1:0] meta_r;
  logic [1:0] meta_nxt;
  logic [1:0] stab_r;
  logic [1:0] stab_nxt;

  always_comb begin
    meta_nxt = {card_io_width_ack_n_in, card_wait_n_in};
    stab_nxt = meta_r;
  end

  // Idle level is high so a quiet pin never stalls a transfer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= 2'h3;
      stab_r <= 2'h3;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
    end
  end

  assign sync.wait_n = stab_r[0];
  assign sync.io_width_ack_n = stab_r[1];
endmodule
`default_nettype wire

// file: core/pcsc_sync_if.sv
// Interface carrying the synchronised card inputs into the controller.
// Assumes both ends sit on the controller clock.
`default_nettype none
interface pcsc_sync_if;
  logic wait_n;
  logic io_width_ack_n;
  modport src (output wait_n, output io_width_ack_n);
  modport dst (input wait_n, input io_width_ack_n);
endinterface
`default_nettype wire

// file: verif/pcsc_card_model.sv
// Card behind steering logic: wait stretch and width acknowledge.
// Assumes both pins have pull-ups, so released means high.
`default_nettype none
module pcsc_card_model (
  input wire logic mclk_in,
  input wire logic strobe_on_in,
  input wire logic io_on_in,
  input wire logic [3:0] stall_in,
  input wire logic wide_in,
  output logic card_wait_n_out,
  output logic card_io_width_ack_n_out
);
  logic [3:0] cnt_r;
  always_ff @(posedge mclk_in) begin
    cnt_r <= !strobe_on_in ? stall_in : (cnt_r == 4'h0 ? 4'h0 : cnt_r - 4'h1);
  end
  // Wait low for stall_in strobe cycles, released otherwise
  assign card_wait_n_out = !strobe_on_in || (cnt_r == 4'h0);
  // Only a wide I/O address is acknowledged
  assign card_io_width_ack_n_out = !(io_on_in && wide_in);
endmodule
`default_nettype wire

// file: verif/pcsc_ctrl_sva.sv
// Port checker for the card strobe controller.
// Assumes access fields are held until done_out.
`default_nettype none
module pcsc_ctrl_sva
  import pcsc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic req_write_in,
  input wire pcsc_pkg::pcsc_space_t req_space_in,
  input wire logic req_socket_in,
  input wire logic [1:0] req_lanes_in,
  input wire logic card_wait_n_in,
  input wire logic busy_out,
  input wire logic card_mem_read_strobe_n_out,
  input wire logic card_mem_write_strobe_n_out,
  input wire logic card_io_read_strobe_n_out,
  input wire logic card_io_write_strobe_n_out,
  input wire logic [1:0] card_lane_enable_n_out,
  input wire logic socket_select_out,
  input wire logic attribute_space_select_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic [3:0] on;
  logic io;
  assign on = ~{card_mem_read_strobe_n_out, card_mem_write_strobe_n_out,
    card_io_read_strobe_n_out, card_io_write_strobe_n_out};
  assign io = (req_space_in == PCSC_SP_IO);
  sequence s_rd; $rose(busy_out) ##0 !req_write_in; endsequence
  sequence s_wr; $rose(busy_out) ##0 req_write_in; endsequence
  property p_mem_rd; s_rd ##0 !io |=> on == 4'h8; endproperty
  property p_mem_wr; s_wr ##0 !io |=> on == 4'h4; endproperty
  property p_io_wr; s_wr ##0 io |=> on == 4'h1; endproperty
  property p_io_rd; s_rd ##0 io |=> on == 4'h2; endproperty
  property p_one; $onehot0(on); endproperty
  property p_lanes; |on |-> card_lane_enable_n_out == ~req_lanes_in; endproperty
  property p_sock; busy_out |-> socket_select_out == req_socket_in; endproperty
  property p_attr; |on |-> attribute_space_select_n_out == (req_space_in != PCSC_SP_ATTR);
  endproperty
  // Sync delay of the wait pin means three low samples before a stretch is owed
  property p_wait; (|on && !card_wait_n_in) [*3] |=> |on; endproperty
  a_mem_rd: assert property (p_mem_rd) else $error("read strobe wrong");
  a_mem_wr: assert property (p_mem_wr) else $error("write strobe wrong");
  a_io_wr: assert property (p_io_wr) else $error("io write strobe wrong");
  a_io_rd: assert property (p_io_rd) else $error("io read strobe wrong");
  a_one: assert property (p_one) else $error("two strobes active");
  a_lanes: assert property (p_lanes) else $error("lane enables wrong");
  a_sock: assert property (p_sock) else $error("socket select wrong");
  a_attr: assert property (p_attr) else $error("attribute select wrong");
  a_wait: assert property (p_wait) else $error("strobe ended in wait");
endmodule
`default_nettype wire

// file: verif/tb_pcsc_ctrl.sv
// Bench for the card strobe controller with the card model.
// Assumes the checker is bound below.
`default_nettype none
module tb_pcsc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import pcsc_pkg::*;
  logic mclk_in = 0, nrst_in = 0, req_in = 0, req_write_in = 0, req_socket_in = 0;
  logic wide = 0, wt_n, ack_n, busy, done, io16, mrd, mwr, ird, iwr, sock, attr_n;
  pcsc_space_t req_space_in = PCSC_SP_COMMON;
  logic [1:0] req_lanes_in = 2'h0, lanes_n;
  logic [3:0] stall = 4'h0;
  int failures = 0, cmp_count = 0;
  initial forever #4 mclk_in = ~mclk_in;
  pcsc_ctrl DUT (.mclk_in, .nrst_in, .req_in, .req_write_in, .req_space_in,
    .req_socket_in, .req_lanes_in, .card_wait_n_in(wt_n), .card_io_width_ack_n_in(ack_n),
    .busy_out(busy), .done_out(done), .io_is_16_out(io16), .card_mem_read_strobe_n_out(mrd),
    .card_mem_write_strobe_n_out(mwr), .card_io_read_strobe_n_out(ird),
    .card_io_write_strobe_n_out(iwr), .card_lane_enable_n_out(lanes_n),
    .socket_select_out(sock), .attribute_space_select_n_out(attr_n));
  pcsc_card_model u_card (.mclk_in, .strobe_on_in(!(mrd && mwr && ird && iwr)),
    .io_on_in(!(ird && iwr)), .stall_in(stall), .wide_in(wide),
    .card_wait_n_out(wt_n), .card_io_width_ack_n_out(ack_n));
  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic xfer(input logic wr, input pcsc_space_t sp, input logic sk,
      input logic [1:0] ln, input logic [3:0] st, input logic wd, output logic [7:0] len);
    logic [3:0] seen;
    logic [7:0] sel_exp;
    logic [7:0] kind_exp;
    int n;
    seen = 4'h0;
    sel_exp = {4'h0, ~ln, sk, sp != PCSC_SP_ATTR};
    kind_exp = (sp == PCSC_SP_IO) ? (wr ? 8'h1 : 8'h2) : (wr ? 8'h4 : 8'h8);
    len = 8'h0;
    n = 0;
    @(posedge mclk_in);
    req_in <= 1'b1;
    req_write_in <= wr;
    req_space_in <= sp;
    req_socket_in <= sk;
    req_lanes_in <= ln;
    stall <= st;
    wide <= wd;
    // Request is ignored once busy, so one cycle is enough
    @(posedge mclk_in);
    req_in <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge mclk_in);
      n++;
      if ({mrd, mwr, ird, iwr} !== 4'hF) begin
        len++;
        // Steering routes the card to the socket named here before the strobe
        if (seen == 4'h0) cmp(8'({lanes_n, sock, attr_n}), sel_exp, "sel");
        seen |= ~{mrd, mwr, ird, iwr};
      end
    end
    if (n >= 200) begin
      failures++;
      print_verdict();
    end
    cmp(8'(seen), kind_exp, "kind");
    cmp(8'({lanes_n, attr_n}), 8'h07, "idle");
    if (sp == PCSC_SP_IO) cmp(8'(io16), 8'(wd), "width");
  endtask
  task automatic sc_modes();
    logic [7:0] len;
    for (int i = 0; i < 8; i++) begin
      xfer(i[0], pcsc_space_t'(i[2:1]), i[1] ^ i[0], 2'(i % 3 + 1), 4'h0, 1'b0, len);
      cmp(len, 8'(PCSC_STROBE_CYC), "length");
    end
  endtask
  task automatic sc_wait();
    logic [7:0] len;
    xfer(1'b1, PCSC_SP_VLIO, 1'b1, 2'h3, 4'hC, 1'b0, len);
    cmp(8'(len > 8'hC), 8'h01, "stretch");
  endtask
  task automatic sc_reset();
    @(posedge mclk_in);
    req_in <= 1'b1;
    req_write_in <= 1'b1;
    req_space_in <= PCSC_SP_ATTR;
    req_socket_in <= 1'b1;
    req_lanes_in <= 2'h3;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp(8'({mrd, mwr, attr_n}), 8'h04, "cut write");
    // Reset lands while the write strobe is low
    @(posedge mclk_in);
    req_in <= 1'b0;
    nrst_in <= 1'b0;
    @(negedge mclk_in);
    cmp(8'({mrd, mwr, ird, iwr, lanes_n, attr_n}), 8'h7F, "reset pins");
    cmp(8'({sock, busy, done, io16}), 8'h00, "reset state");
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    cmp(8'({sock, busy, done, mrd, mwr, ird, iwr}), 8'h0F, "after reset");
  endtask
  task automatic sc_width();
    logic [7:0] len;
    xfer(1'b0, PCSC_SP_IO, 1'b0, 2'h3, 4'h0, 1'b1, len);
    xfer(1'b1, PCSC_SP_IO, 1'b1, 2'h1, 4'h3, 1'b0, len);
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    sc_modes();
    sc_wait();
    sc_reset();
    sc_width();
    print_verdict();
  end
endmodule
bind pcsc_ctrl pcsc_ctrl_sva u_sva (
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .req_write_in(req_write_in),
  .req_space_in(req_space_in),
  .req_socket_in(req_socket_in),
  .req_lanes_in(req_lanes_in),
  .card_wait_n_in(card_wait_n_in),
  .busy_out(busy_out),
  .card_mem_read_strobe_n_out(card_mem_read_strobe_n_out),
  .card_mem_write_strobe_n_out(card_mem_write_strobe_n_out),
  .card_io_read_strobe_n_out(card_io_read_strobe_n_out),
  .card_io_write_strobe_n_out(card_io_write_strobe_n_out),
  .card_lane_enable_n_out(card_lane_enable_n_out),
  .socket_select_out(socket_select_out),
  .attribute_space_select_n_out(attribute_space_select_n_out)
);
`default_nettype wire
